// file: hdl/eiec_map.svh
// register map and sizing constants for the external edge event controller
// Overview of operation
// (RQ1) 23 lines each raise interrupt or event
// (RQ2) per line: rising, falling or both edges
// (RQ3) per-line mask blocks forwarding of requests
// (RQ4) pending bit records each detected interrupt request
// (RQ5) pulses shorter than clock period still caught
// (RQ6) 16 pin lines, source chosen among 140
// (RQ7) pending sticky until software writes one
`ifndef EIEC_MAP_SVH
`define EIEC_MAP_SVH

`define EIEC_NLINES      23
`define EIEC_NPINLINES   16
`define EIEC_NPINS       140
`define EIEC_SELW        8
`define EIEC_AW          12

`define EIEC_OFS_IMASK   12'h000
`define EIEC_OFS_EMASK   12'h004
`define EIEC_OFS_RISE    12'h008
`define EIEC_OFS_FALL    12'h00C
`define EIEC_OFS_PEND    12'h014
`define EIEC_OFS_SEL0    12'h020
`define EIEC_SEL_WORDS   4

`define EIEC_RST_VEC     23'h00_0000
`define EIEC_RST_SEL     8'h00
`define EIEC_RST_WORD    32'h0000_0000

`endif

// file: hdl/eiec_pkg.sv
// types shared by the external edge event controller
`include "eiec_map.svh"
package eiec_pkg;
    typedef logic [`EIEC_NLINES-1:0] eiec_vec_type;
    typedef logic [`EIEC_SELW-1:0]   eiec_sel_type;
    typedef enum logic {
        EIEC_RISE = 1'b0,
        EIEC_FALL = 1'b1
    } eiec_edge_type;
endpackage : eiec_pkg

// file: hdl/eiec_edge.sv
// one line's edge catcher: asynchronous capture plus handshake into the clock
`timescale 1ns/100ps
`default_nettype none
module eiec_edge
    import eiec_pkg::*;
(
    input  wire logic clk_i,     // system clock
    input  wire logic rst_n_i,   // synchronous reset, low active
    input  wire logic src_i,     // raw line level
    output logic      rise_o,    // one-cycle pulse per rising edge
    output logic      fall_o     // one-cycle pulse per falling edge
);
    wire  [1:0] cap;
    logic [1:0] s1_ff;
    logic [1:0] s2_ff;
    logic [1:0] ack_ff;
    wire  [1:0] edge_clk  = {~src_i, src_i};
    wire  [1:0] pulse     = s2_ff & ~ack_ff;

    // the line itself clocks the capture flop, so a pulse far narrower than
    // the system clock still leaves a mark; an edge inside the short ack
    // window (about three cycles) after a previous one merges with it
    genvar e;
    for (e = 0; e < 2; e++) begin : g_edge
        logic cap_ff;

        always_ff @(posedge edge_clk[e] or posedge ack_ff[e]) begin   // see RQ5
            if (ack_ff[e]) begin
                cap_ff <= 1'b0;
            end else begin
                cap_ff <= 1'b1;
            end
        end
        assign cap[e] = cap_ff;

        sequence s_pulse_out;
            ##[1:3] pulse[e];
        endsequence
        property p_cap_seen;
            @(posedge clk_i) disable iff (!rst_n_i)
            $rose(cap[e]) |-> s_pulse_out;
        endproperty
        a_cap_seen: assert property (p_cap_seen) else $error("captured edge not reported"); // see RQ5

        property p_ack_release;
            @(posedge clk_i) disable iff (!rst_n_i)
            $rose(ack_ff[e]) |-> ##[1:4] !ack_ff[e];
        endproperty
        a_ack_release: assert property (p_ack_release) else $error("edge catcher stuck"); // see RQ5
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_ff  <= 2'b00;
            s2_ff  <= 2'b00;
            ack_ff <= 2'b11;
        end else begin
            s1_ff  <= cap;
            s2_ff  <= s1_ff;
            ack_ff <= s2_ff;
        end
    end

    assign rise_o = pulse[EIEC_RISE];
    assign fall_o = pulse[EIEC_FALL];
endmodule : eiec_edge
`default_nettype wire

// file: hdl/eiec_top.sv
// external edge event controller with apb register access
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "eiec_map.svh"
module eiec_top
    import eiec_pkg::*;
#(
    parameter int NLINES = `EIEC_NLINES,
    parameter int NPINL  = `EIEC_NPINLINES,
    parameter int NPINS  = `EIEC_NPINS
) (
    input  wire logic                   REF_CLK_I,   // 200 MHz clock
    input  wire logic                   RESETN_I,    // synchronous reset, low active
    input  wire logic                   PSEL_I,      // apb select
    input  wire logic                   PENABLE_I,   // apb enable
    input  wire logic                   PWRITE_I,    // apb direction
    input  wire logic [`EIEC_AW-1:0]    PADDR_I,     // apb byte address
    input  wire logic [31:0]            PWDATA_I,    // apb write data
    output logic      [31:0]            PRDATA_O,    // apb read data
    output logic                        PREADY_O,    // apb ready
    output logic                        PSLVERR_O,   // unmapped address
    input  wire logic [NPINS-1:0]       GPIO_I,      // general-purpose pin levels
    input  wire logic [NLINES-NPINL-1:0] INT_EVT_I,  // internal event lines
    output logic      [NLINES-1:0]      IRQ_O,       // interrupt request levels
    output logic      [NLINES-1:0]      EVT_O        // event request pulses
);
    eiec_vec_type imask_ff;
    eiec_vec_type emask_ff;
    eiec_vec_type rise_en_ff;
    eiec_vec_type fall_en_ff;
    eiec_vec_type pend_ff;
    eiec_vec_type nxt_pend;
    eiec_vec_type irq_ff;
    eiec_vec_type evt_ff;
    eiec_sel_type sel_ff [NPINL];
    logic [31:0]  rdata_ff;
    logic         ready_ff;
    logic         err_ff;

    // apb decode: answer in the first cycle of the access phase, no wait state
    wire setup    = PSEL_I & ~PENABLE_I;
    wire access   = PSEL_I & PENABLE_I & ready_ff;
    wire is_imask = (PADDR_I == `EIEC_OFS_IMASK);
    wire is_emask = (PADDR_I == `EIEC_OFS_EMASK);
    wire is_rise  = (PADDR_I == `EIEC_OFS_RISE);
    wire is_fall  = (PADDR_I == `EIEC_OFS_FALL);
    wire is_pend  = (PADDR_I == `EIEC_OFS_PEND);
    // the four select words share one 16-byte slot; only aligned words hit
    wire is_sel   = (PADDR_I[`EIEC_AW-1:4] == 8'(`EIEC_OFS_SEL0 >> 4))
                    && (PADDR_I[1:0] == 2'b00);
    wire [1:0] sel_word = PADDR_I[3:2];
    wire addr_hit = is_imask | is_emask | is_rise | is_fall | is_pend | is_sel;
    wire wr       = access & PWRITE_I & addr_hit;
    wire [31:0] sel_rd [`EIEC_SEL_WORDS];

    wire eiec_vec_type clr_vec = (wr && is_pend) ? PWDATA_I[NLINES-1:0] : `EIEC_RST_VEC;

    wire [31:0] rd_mux =
        is_imask ? {9'h000, imask_ff}   :
        is_emask ? {9'h000, emask_ff}   :
        is_rise  ? {9'h000, rise_en_ff} :
        is_fall  ? {9'h000, fall_en_ff} :
        is_pend  ? {9'h000, pend_ff}    :
        is_sel   ? sel_rd[sel_word]     : `EIEC_RST_WORD;

    // line sources and edge detection
    eiec_vec_type src;
    eiec_vec_type rise_p;
    eiec_vec_type fall_p;
    eiec_vec_type hit;

    genvar k;
    for (k = 0; k < NLINES; k++) begin : g_line
        if (k < NPINL) begin : g_pin
            assign src[k] = GPIO_I[sel_ff[k]];   // see RQ6
            // selects past the last pin are refused, so the index stays in range
            always_ff @(posedge REF_CLK_I) begin
                if (!RESETN_I) begin
                    sel_ff[k] <= `EIEC_RST_SEL;
                end else if (wr && is_sel && sel_word == 2'(k / 4)
                             && PWDATA_I[8*(k%4)+:8] < 8'(NPINS)) begin
                    sel_ff[k] <= PWDATA_I[8*(k%4)+:8];   // see RQ6
                end
            end
            property p_sel_range;
                @(posedge REF_CLK_I) disable iff (!RESETN_I)
                sel_ff[k] < 8'(NPINS);
            endproperty
            a_sel_range: assert property (p_sel_range) else $error("pin select out of range"); // see RQ6
        end else begin : g_int
            assign src[k] = INT_EVT_I[k-NPINL];
        end
        eiec_edge u_edge (
            .clk_i   (REF_CLK_I),
            .rst_n_i (RESETN_I),
            .src_i   (src[k]),
            .rise_o  (rise_p[k]),
            .fall_o  (fall_p[k])
        );   // see RQ1
    end

    for (k = 0; k < `EIEC_SEL_WORDS; k++) begin : g_selrd
        assign sel_rd[k] = {sel_ff[4*k+3], sel_ff[4*k+2], sel_ff[4*k+1], sel_ff[4*k]};
    end

    assign hit      = (rise_p & rise_en_ff) | (fall_p & fall_en_ff);   // see RQ2
    // a new request in the clearing cycle wins over the clear
    assign nxt_pend = (pend_ff & ~clr_vec) | (hit & imask_ff);         // see RQ4, see RQ7

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            imask_ff   <= `EIEC_RST_VEC;
            emask_ff   <= `EIEC_RST_VEC;
            rise_en_ff <= `EIEC_RST_VEC;
            fall_en_ff <= `EIEC_RST_VEC;
        end else if (wr) begin
            if (is_imask) imask_ff   <= PWDATA_I[NLINES-1:0];   // see RQ3
            if (is_emask) emask_ff   <= PWDATA_I[NLINES-1:0];   // see RQ3
            if (is_rise)  rise_en_ff <= PWDATA_I[NLINES-1:0];   // see RQ2
            if (is_fall)  fall_en_ff <= PWDATA_I[NLINES-1:0];   // see RQ2
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            pend_ff  <= `EIEC_RST_VEC;
            irq_ff   <= `EIEC_RST_VEC;
            evt_ff   <= `EIEC_RST_VEC;
            ready_ff <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= `EIEC_RST_WORD;
        end else begin
            pend_ff  <= nxt_pend;
            irq_ff   <= pend_ff & imask_ff;   // see RQ3
            evt_ff   <= hit & emask_ff;       // see RQ1, see RQ3
            ready_ff <= setup;
            err_ff   <= setup & ~addr_hit;
            if (setup) rdata_ff <= rd_mux;
        end
    end

    assign PRDATA_O  = rdata_ff;
    assign PREADY_O  = ready_ff;
    assign PSLVERR_O = err_ff;
    assign IRQ_O     = irq_ff;
    assign EVT_O     = evt_ff;

    // checked per polarity: a short pulse on a both-edge line may legally
    // give two events in consecutive cycles
    property p_evt_single;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        1'b1 |=> (((rise_p & $past(rise_p)) | (fall_p & $past(fall_p))) == `EIEC_RST_VEC);
    endproperty
    a_evt_single: assert property (p_evt_single) else $error("edge pulse longer than one cycle"); // see RQ1

    property p_trig_sel;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (hit & ~(rise_en_ff | fall_en_ff)) == `EIEC_RST_VEC;
    endproperty
    a_trig_sel: assert property (p_trig_sel) else $error("request on disabled trigger"); // see RQ2

    property p_irq_masked;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        1'b1 |=> ((IRQ_O & ~$past(imask_ff)) == `EIEC_RST_VEC);
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked line raised irq"); // see RQ3

    property p_pend_set;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (hit & imask_ff) != `EIEC_RST_VEC |=> ##1
            ((IRQ_O & $past(hit & imask_ff, 2)) == $past(hit & imask_ff, 2));
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("request not pending"); // see RQ4

    property p_pend_sticky;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        1'b1 |=> (($past(pend_ff) & ~$past(clr_vec) & ~pend_ff) == `EIEC_RST_VEC);
    endproperty
    a_pend_sticky: assert property (p_pend_sticky) else $error("pending lost without clear"); // see RQ7

    property p_pend_clear;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (clr_vec != `EIEC_RST_VEC && hit == `EIEC_RST_VEC)
            |=> ((pend_ff & $past(clr_vec)) == `EIEC_RST_VEC);
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("write one did not clear"); // see RQ7
endmodule : eiec_top
`default_nettype wire

// file: tb/eiec_pin_model.sv
// pin and event-counter model around the edge event controller
`timescale 1ns/100ps
`default_nettype none
module eiec_pin_model
    import eiec_pkg::*;
#(
    parameter int NPINS = 140
) (
    input  wire logic              clk_i,   // system clock
    input  wire eiec_vec_type      evt_i,   // event pulses from the block
    output logic       [NPINS-1:0] gpio_o,  // pin levels
    output logic       [6:0]       int_o    // internal event levels
);
    int evt_cnt [23];

    initial begin
        gpio_o = '0;
        int_o  = '0;
        foreach (evt_cnt[i]) evt_cnt[i] = 0;
    end

    // per-line counts expose merged, lost or stretched event pulses
    always @(posedge clk_i) begin
        foreach (evt_cnt[i]) begin
            if (evt_i[i] === 1'b1) evt_cnt[i]++;
        end
    end

    // index NPINS and up selects an internal line; pins get the same width_ns pulse as internal lines
    task automatic pulse(input int idx, input real width_ns);
        begin
            #1.2;
            if (idx < NPINS) gpio_o[idx] = 1'b1;
            else int_o[idx-NPINS] = 1'b1;
            #(width_ns);
            if (idx < NPINS) gpio_o[idx] = 1'b0;
            else int_o[idx-NPINS] = 1'b0;
        end
    endtask : pulse
endmodule : eiec_pin_model
`default_nettype wire

// file: tb/test_edge_interrupt_event_lines.sv
// self-checking bench for the external edge event controller
`timescale 1ns/100ps
`default_nettype none
`include "eiec_map.svh"
module test_edge_interrupt_event_lines
    import eiec_pkg::*;
;
    logic         clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, q;
    logic [139:0] gpio;
    logic [6:0]   int_evt;
    eiec_vec_type irq, evt;
    int           num_errors = 0;
    int           n_tests = 0;
    int           cyc = 0;
    logic [11:0]  ofs [6] = '{`EIEC_OFS_IMASK, `EIEC_OFS_EMASK, `EIEC_OFS_RISE,
                              `EIEC_OFS_FALL, `EIEC_OFS_PEND, `EIEC_OFS_SEL0};

    eiec_top u_dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .GPIO_I(gpio), .INT_EVT_I(int_evt),
        .IRQ_O(irq), .EVT_O(evt));
    eiec_pin_model u_pins (.clk_i(clk), .evt_i(evt), .gpio_o(gpio), .int_o(int_evt));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    task automatic report_and_stop;
        begin
            $display("checks %0d, mismatches %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask : report_and_stop

    // a stuck bus or lost handshake ends up here instead of hanging
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            $display("mismatch at %0t: timeout", $time);
            report_and_stop;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        begin
            n_tests++;
            if (got !== exp) begin
                num_errors++;
                $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
            end
        end
    endtask : chk

    // entered right after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        begin
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= wr;
            paddr   <= a;
            pwdata  <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) begin
                @(posedge clk);
            end
            q = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        begin
            apb(1'b0, a, 32'h0000_0000);
            chk(q, exp, "register read");
        end
    endtask : rd

    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (ofs[i]) rd(ofs[i], `EIEC_RST_WORD);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk({30'h0, e, q[0]}, 32'h0000_0002, "unmapped read");
        apb(1'b1, `EIEC_OFS_IMASK, 32'h0001_0007);
        apb(1'b1, `EIEC_OFS_EMASK, 32'h0001_000F);
        apb(1'b1, `EIEC_OFS_RISE, 32'h0001_000D);
        apb(1'b1, `EIEC_OFS_FALL, 32'h0000_0006);
        apb(1'b1, `EIEC_OFS_SEL0, 32'h098B_0705);
        apb(1'b1, `EIEC_OFS_SEL0, 32'h098B_078C);
        rd(`EIEC_OFS_SEL0, 32'h098B_0705);
        u_pins.pulse(5, 2.0);
        u_pins.pulse(7, 2.0);
        u_pins.pulse(139, 40.0);
        u_pins.pulse(9, 2.0);
        u_pins.pulse(140, 2.0);
        repeat (10) @(posedge clk);
        chk(u_pins.evt_cnt[0], 32'h0000_0001, "rise-only events");
        chk(u_pins.evt_cnt[1], 32'h0000_0001, "fall-only events");
        chk(u_pins.evt_cnt[2], 32'h0000_0002, "both-edge events");
        chk(u_pins.evt_cnt[3], 32'h0000_0001, "masked line event");
        chk(u_pins.evt_cnt[16], 32'h0000_0001, "internal event");
        rd(`EIEC_OFS_PEND, 32'h0001_0007);
        chk({9'h0, irq}, 32'h0001_0007, "irq levels");
        apb(1'b1, `EIEC_OFS_PEND, 32'h0000_0000);
        rd(`EIEC_OFS_PEND, 32'h0001_0007);
        apb(1'b1, `EIEC_OFS_PEND, 32'h0000_0001);
        rd(`EIEC_OFS_PEND, 32'h0001_0006);
        chk({9'h0, irq}, 32'h0001_0006, "irq after clear");
        apb(1'b1, `EIEC_OFS_EMASK, 32'h0000_0000);
        u_pins.pulse(5, 2.0);
        repeat (10) @(posedge clk);
        chk(u_pins.evt_cnt[0], 32'h0000_0001, "event-masked line");
        rd(`EIEC_OFS_PEND, 32'h0001_0007);
        apb(1'b1, `EIEC_OFS_IMASK, 32'h0000_0000);
        @(posedge clk);
        chk({9'h0, irq}, 32'h0000_0000, "irq after mask off");
        report_and_stop;
    end
endmodule : test_edge_interrupt_event_lines
`default_nettype wire
